// File: bench/sdi_regs_checker_properties.sv
// Port checks for the EDH, format and payload register bank
`timescale 1ns/10ps
`default_nettype none
module sdi_regs_checker (
	input wire logic				CLK_SYS,
	input wire logic				RESET,
	input wire logic [sdi_regs_pkg::ADDR_W-1:0]	REG_ADDR,
	input wire logic				REG_RE,
	input wire logic [sdi_regs_pkg::DATA_W-1:0]	REG_RDATA,
	input wire logic				EDH_UPDATE_CONTROL,
	input wire logic				PAYLOAD_INSERT_DISABLE,
	input wire logic [sdi_regs_pkg::EDH_FLAG_W-1:0]	EDH_FLAGS_IN,
	input wire logic [sdi_regs_pkg::EDH_FLAG_W-1:0]	EDH_FLAGS_OUT,
	input wire logic				PAYLOAD_INSERT_ENABLE
);
	import sdi_regs_pkg::*;
	logic			rd_r;
	logic			live_r;
	logic [ADDR_W-1:0]	ra_r;
	// Reads during reset are not taken, so they never arm a check
	always_ff @(posedge CLK_SYS) begin
		rd_r <= REG_RE && !RESET;
		ra_r <= REG_ADDR;
		live_r <= !RESET;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	flag_reserved_a:
		assert property (rd_r && ra_r == 8'h03 |-> !REG_RDATA[15]) else $error("flag bit 15 set");
	anc_unknown_read_a:
		assert property (rd_r && ra_r == 8'h03 |-> REG_RDATA[14] == $past(EDH_FLAGS_IN[14]))
			else $error("flag bit 14 read wrong");
	anc_unknown_out_a:
		assert property (live_r |-> EDH_FLAGS_OUT[14] == $past(EDH_FLAGS_IN[14]))
			else $error("outgoing bit 14 wrong");
	edh_passthru_a:
		assert property (EDH_UPDATE_CONTROL |=> EDH_FLAGS_OUT == $past(EDH_FLAGS_IN))
			else $error("incoming flags not kept");
	override_read_a:
		assert property (rd_r && ra_r == 8'h06 |-> REG_RDATA[15:6] == 10'h000)
			else $error("override reserved bits set");
	position_read_a:
		assert property (rd_r && ra_r == 8'h08 |-> REG_RDATA[15:1] == 15'h0000)
			else $error("position reserved bits set");
	insert_enable_a:
		assert property (live_r |-> PAYLOAD_INSERT_ENABLE == !$past(PAYLOAD_INSERT_DISABLE))
			else $error("insert enable wrong");
	reserved_read_a:
		assert property (rd_r && (ra_r inside {8'h05, 8'h09} || ra_r < 8'h03 || ra_r > 8'h0d)
			|-> REG_RDATA == 16'h0000) else $error("reserved word nonzero");
endmodule : sdi_regs_checker
bind sdi_edh_format_payload_regs sdi_regs_checker sdi_regs_checker_i (.*);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the EDH, format and payload register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sdi_regs_pkg::*;
	logic			CLK_SYS = 1'b0, RESET = 1'b1, REG_WE = 1'b0, REG_RE = 1'b0;
	logic [ADDR_W-1:0]	REG_ADDR = 8'h00;
	logic [DATA_W-1:0]	REG_WDATA = 16'h0000, REG_RDATA;
	logic			EDH_UPDATE_CONTROL = 1'b0, PAYLOAD_INSERT_DISABLE = 1'b0;
	logic [EDH_FLAG_W-1:0]	EDH_FLAGS_IN = 15'h0000, EDH_FLAGS_OUT;
	logic			H_LOCK_IN = 1'b0, V_LOCK_IN = 1'b0, STANDARD_LOCKED_IN = 1'b0;
	logic			INTERLACE_FLAG_IN = 1'b0, FULL_FIELD_VALIDITY_IN = 1'b0;
	logic			ACTIVE_PICTURE_VALIDITY_IN = 1'b0, REG_RVALID, PAYLOAD_INSERT_ENABLE;
	logic			EARLIEST_SPACE_SELECT;
	logic [STD_W-1:0]	FLYWHEEL_STANDARD_IN = 5'h00, ACTIVE_STANDARD;
	logic [31:0]		LUMA_PAYLOAD, CHROMA_PAYLOAD;
	logic [7:0]		addrs [13] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
				8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h20};
	int			error_cnt = 0;
	int			cmp_count = 0;
	sdi_edh_format_payload_regs sdi_edh_format_payload_regs_i (.*);
	always #25 CLK_SYS = ~CLK_SYS;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK_SYS) #1;
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WE = 1'b1;
		@(posedge CLK_SYS) #1;
		REG_WE = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge CLK_SYS) #1;
		REG_ADDR = a;
		REG_RE = 1'b1;
		@(posedge CLK_SYS) #1;
		REG_RE = 1'b0;
		check(32'(REG_RVALID), 32'h1);
		check(32'(REG_RDATA), 32'(exp));
	endtask : rd
	// Outputs trail their cause by up to two registered stages
	task automatic settle;
		repeat (2) @(posedge CLK_SYS);
		#1;
	endtask : settle
	function automatic logic [15:0] wmask(input logic [7:0] a);
		case (a)
			8'h03: return 16'h3fff;
			8'h06: return 16'h003f;
			8'h08: return 16'h0001;
			8'h0a, 8'h0b, 8'h0c, 8'h0d: return 16'hffff;
			default: return 16'h0000;
		endcase
	endfunction : wmask
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(posedge CLK_SYS);
		#1;
		RESET = 1'b0;
		foreach (addrs[i]) rd(addrs[i], (addrs[i] == 8'h08) ? 16'h0001 : 16'h0000);
		foreach (addrs[i]) begin
			wr(addrs[i], 16'hffff);
			rd(addrs[i], wmask(addrs[i]));
		end
		wr(8'h0a, 16'h1234);
		wr(8'h0b, 16'h5678);
		wr(8'h0c, 16'h9abc);
		wr(8'h0d, 16'hdef0);
		settle();
		check(LUMA_PAYLOAD, 32'h56781234);
		check(CHROMA_PAYLOAD, 32'hdef09abc);
		{H_LOCK_IN, V_LOCK_IN, STANDARD_LOCKED_IN, INTERLACE_FLAG_IN} = 4'b1011;
		{FLYWHEEL_STANDARD_IN, FULL_FIELD_VALIDITY_IN, ACTIVE_PICTURE_VALIDITY_IN} = 7'h56;
		rd(8'h04, 16'h02b5);
		rd(8'h07, 16'h0002);
		{H_LOCK_IN, V_LOCK_IN, STANDARD_LOCKED_IN, INTERLACE_FLAG_IN} = 4'b0100;
		{FLYWHEEL_STANDARD_IN, FULL_FIELD_VALIDITY_IN, ACTIVE_PICTURE_VALIDITY_IN} = 7'h29;
		rd(8'h04, 16'h0142);
		rd(8'h07, 16'h0001);
		settle();
		check(32'(ACTIVE_STANDARD), 32'h1f);
		wr(8'h06, 16'h0011);
		settle();
		check(32'(ACTIVE_STANDARD), 32'h0a);
		wr(8'h06, 16'h0031);
		settle();
		check(32'(ACTIVE_STANDARD), 32'h11);
		wr(8'h03, 16'h2aaa);
		EDH_FLAGS_IN = 15'h4155;
		settle();
		check(32'(EDH_FLAGS_OUT), 32'h6aaa);
		rd(8'h03, 16'h6aaa);
		EDH_UPDATE_CONTROL = 1'b1;
		settle();
		check(32'(EDH_FLAGS_OUT), 32'h4155);
		wr(8'h08, 16'h0000);
		settle();
		check(32'(EARLIEST_SPACE_SELECT), 32'h0);
		PAYLOAD_INSERT_DISABLE = 1'b1;
		settle();
		check(32'(PAYLOAD_INSERT_ENABLE), 32'h0);
		RESET = 1'b1;
		settle();
		RESET = 1'b0;
		rd(8'h08, 16'h0001);
		rd(8'h0d, 16'h0000);
		summarize();
	end
	// Hang guard: a stuck run ends as a failure
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		error_cnt++;
		summarize();
	end
endmodule : testbench
`default_nettype wire

// File: rtl/host_word_reg.sv
// One host-writable 16-bit word with per-bit write mask and reset value
`timescale 1ns/10ps
`default_nettype none
module host_word_reg
	import sdi_regs_pkg::*;
#(
	parameter logic [DATA_W-1:0] WMASK   = 16'hffff,
	parameter logic [DATA_W-1:0] RST_VAL = 16'h0000
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              wr_en,
	input  wire logic [DATA_W-1:0] wr_data,
	output logic      [DATA_W-1:0] value
);
	logic [DATA_W-1:0] word_r;
	logic [DATA_W-1:0] word_nxt;

	// Masked bits keep their reset value, so read-only bits never take a write
	assign word_nxt = wr_en ? ((wr_data & WMASK) | (RST_VAL & ~WMASK)) : word_r;
	assign value    = word_r;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			word_r <= RST_VAL;
		end else begin
			word_r <= word_nxt;
		end
	end
endmodule : host_word_reg
`default_nettype wire

// File: rtl/sdi_edh_format_payload_regs.sv
// EDH flag, format status, standard override and 352M payload register bank
//
// Behaviour
// - The flag register holds five ancillary, five full-field and five active-picture flags in bits 14..0, bit 15 reads zero.
// - Flag bit 14 is read-only and follows the incoming flag, the other fourteen flag bits are host read/write and reset to zero.
// - With the update control low the programmed flags go into outgoing EDH packets, with it high the incoming flags are kept.
// - Format status shows standard lock at bit 2, vertical lock at bit 1 and horizontal lock at bit 0, active high and read-only.
// - Format status shows interlace at bit 4 (high interlaced) and the five-bit detected standard in bits 9..5.
// - When override bit 5 is high the host code in bits 4..0 replaces the flywheel standard.
// - The validity status register shows the full-field bit at 1 and the active-picture bit at 0, read-only.
// - Position bit 0, reset 1, selects first available ancillary space when high and right after EAV and CRC when low.
// - Luma payload bytes 1..4 sit in two host-writable words, odd byte low and even byte high.
// - Chroma payload bytes 1 and 2 sit in bits 7..0 and 15..8 of the next word and reset to zero.
// - Chroma payload bytes 3 and 4 sit in the following word at bits 7..0 and 15..8.
// - Payload packets are inserted unless the processing disable bit is high.
`timescale 1ns/10ps
`default_nettype none
module sdi_edh_format_payload_regs (
	input  wire logic                           CLK_SYS,
	input  wire logic                           RESET,
	input  wire logic [sdi_regs_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic [sdi_regs_pkg::DATA_W-1:0] REG_WDATA,
	input  wire logic                           REG_WE,
	input  wire logic                           REG_RE,
	output logic      [sdi_regs_pkg::DATA_W-1:0] REG_RDATA,
	output logic                                REG_RVALID,
	input  wire logic                           EDH_UPDATE_CONTROL,
	input  wire logic                           PAYLOAD_INSERT_DISABLE,
	input  wire logic [sdi_regs_pkg::EDH_FLAG_W-1:0] EDH_FLAGS_IN,
	input  wire logic                           H_LOCK_IN,
	input  wire logic                           V_LOCK_IN,
	input  wire logic                           STANDARD_LOCKED_IN,
	input  wire logic                           INTERLACE_FLAG_IN,
	input  wire logic [sdi_regs_pkg::STD_W-1:0] FLYWHEEL_STANDARD_IN,
	input  wire logic                           FULL_FIELD_VALIDITY_IN,
	input  wire logic                           ACTIVE_PICTURE_VALIDITY_IN,
	output logic      [sdi_regs_pkg::EDH_FLAG_W-1:0] EDH_FLAGS_OUT,
	output logic      [sdi_regs_pkg::STD_W-1:0] ACTIVE_STANDARD,
	output logic                                PAYLOAD_INSERT_ENABLE,
	output logic                                EARLIEST_SPACE_SELECT,
	output logic      [31:0]                    LUMA_PAYLOAD,
	output logic      [31:0]                    CHROMA_PAYLOAD
);
	import sdi_regs_pkg::*;

	// Writable words: flags, override, position, four payload words
	localparam int NUM_WR = 7;
	localparam logic [ADDR_W-1:0] WR_OFS   [NUM_WR] = '{OFS_EDH_FLAG_PROGRAM,
		OFS_STANDARD_OVERRIDE, OFS_INSERT_POSITION, OFS_LUMA_LOW, OFS_LUMA_HIGH,
		OFS_CHROMA_LOW, OFS_CHROMA_HIGH};
	localparam logic [DATA_W-1:0] WR_MASK  [NUM_WR] = '{EDH_FLAG_WMASK, OVR_WMASK,
		POS_WMASK, PAYLOAD_WMASK, PAYLOAD_WMASK, PAYLOAD_WMASK, PAYLOAD_WMASK};
	localparam logic [DATA_W-1:0] WR_RST   [NUM_WR] = '{EDH_FLAG_RST, OVR_RST,
		POS_RST, PAYLOAD_RST, PAYLOAD_RST, PAYLOAD_RST, PAYLOAD_RST};

	logic [DATA_W-1:0]     wr_value [NUM_WR];
	logic [DATA_W-1:0]     edh_flag_program;
	logic [DATA_W-1:0]     standard_override;
	logic [DATA_W-1:0]     payload_insert_position;
	logic [DATA_W-1:0]     luma_payload_bytes_low;
	logic [DATA_W-1:0]     luma_payload_bytes_high;
	logic [DATA_W-1:0]     chroma_payload_bytes_low;
	logic [DATA_W-1:0]     chroma_payload_bytes_high;
	logic [DATA_W-1:0]     edh_flag_view;
	logic [DATA_W-1:0]     format_detect_status;
	logic [DATA_W-1:0]     edh_validity_status;
	logic [DATA_W-1:0]     rd_mux;
	logic                  override_enable;
	logic [STD_W-1:0]      forced_standard_code;
	logic [EDH_FLAG_W-1:0] programmed_flags;
	logic [EDH_FLAG_W-1:0] edh_flags_nxt;
	logic [STD_W-1:0]      standard_nxt;
	logic [DATA_W-1:0]     rdata_r;
	logic                  rvalid_r;
	logic [EDH_FLAG_W-1:0] edh_flags_r;
	logic [STD_W-1:0]      standard_r;
	logic                  insert_en_r;
	logic                  earliest_r;
	logic [31:0]           luma_r;
	logic [31:0]           chroma_r;

	// Writes to reserved or read-only words match no entry and are dropped
	generate
		for (genvar i = 0; i < NUM_WR; i++) begin : g_wr
			host_word_reg #(
				.WMASK   (WR_MASK[i]),
				.RST_VAL (WR_RST[i])
			) u_word (
				.clk_sys (CLK_SYS),
				.reset   (RESET),
				.wr_en   (REG_WE && (REG_ADDR == WR_OFS[i])),
				.wr_data (REG_WDATA),
				.value   (wr_value[i])
			);
		end
	endgenerate

	assign edh_flag_program          = wr_value[0];
	assign standard_override         = wr_value[1];
	assign payload_insert_position   = wr_value[2];
	assign luma_payload_bytes_low    = wr_value[3];
	assign luma_payload_bytes_high   = wr_value[4];
	assign chroma_payload_bytes_low  = wr_value[5];
	assign chroma_payload_bytes_high = wr_value[6];

	// Bit 14 is not host-owned; it follows the incoming unknown-error flag
	assign programmed_flags = {EDH_FLAGS_IN[EDH_ANC_UNKNOWN_BIT],
		edh_flag_program[EDH_ANC_UNKNOWN_BIT-1:0]};
	assign edh_flag_view    = {1'b0, programmed_flags};

	assign format_detect_status = {6'h00, FLYWHEEL_STANDARD_IN, INTERLACE_FLAG_IN, 1'b0,
		STANDARD_LOCKED_IN, V_LOCK_IN, H_LOCK_IN};
	assign edh_validity_status  = {14'h0000, FULL_FIELD_VALIDITY_IN,
		ACTIVE_PICTURE_VALIDITY_IN};

	assign override_enable      = standard_override[OVR_ENABLE_BIT];
	assign forced_standard_code = standard_override[OVR_CODE_LSB +: STD_W];

	// Read decode; reserved words and unmapped addresses read zero
	assign rd_mux =
		(REG_ADDR == OFS_EDH_FLAG_PROGRAM)  ? edh_flag_view :
		(REG_ADDR == OFS_FORMAT_DETECT)     ? format_detect_status :
		(REG_ADDR == OFS_STANDARD_OVERRIDE) ? standard_override :
		(REG_ADDR == OFS_EDH_VALIDITY)      ? edh_validity_status :
		(REG_ADDR == OFS_INSERT_POSITION)   ? payload_insert_position :
		(REG_ADDR == OFS_LUMA_LOW)          ? luma_payload_bytes_low :
		(REG_ADDR == OFS_LUMA_HIGH)         ? luma_payload_bytes_high :
		(REG_ADDR == OFS_CHROMA_LOW)        ? chroma_payload_bytes_low :
		(REG_ADDR == OFS_CHROMA_HIGH)       ? chroma_payload_bytes_high :
		16'h0000;

	// Flag source for outgoing EDH packets
	assign edh_flags_nxt = EDH_UPDATE_CONTROL ? EDH_FLAGS_IN : programmed_flags;
	// Override swaps the flywheel code for the host code
	assign standard_nxt  = override_enable ? forced_standard_code
		: FLYWHEEL_STANDARD_IN;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= REG_RE ? rd_mux : rdata_r;
			rvalid_r <= REG_RE;
		end
	end

	// Outputs registered so the inserters see glitch-free values
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			edh_flags_r <= 15'h0000;
			standard_r  <= 5'h00;
			insert_en_r <= 1'b0;
			earliest_r  <= POS_RST[POS_EARLIEST_BIT];
			luma_r      <= 32'h0000_0000;
			chroma_r    <= 32'h0000_0000;
		end else begin
			edh_flags_r <= edh_flags_nxt;
			standard_r  <= standard_nxt;
			insert_en_r <= ~PAYLOAD_INSERT_DISABLE;
			earliest_r  <= payload_insert_position[POS_EARLIEST_BIT];
			luma_r      <= {luma_payload_bytes_high, luma_payload_bytes_low};
			chroma_r    <= {chroma_payload_bytes_high, chroma_payload_bytes_low};
		end
	end

	assign REG_RDATA             = rdata_r;
	assign REG_RVALID            = rvalid_r;
	assign EDH_FLAGS_OUT         = edh_flags_r;
	assign ACTIVE_STANDARD       = standard_r;
	assign PAYLOAD_INSERT_ENABLE = insert_en_r;
	assign EARLIEST_SPACE_SELECT = earliest_r;
	assign LUMA_PAYLOAD          = luma_r;
	assign CHROMA_PAYLOAD        = chroma_r;
endmodule : sdi_edh_format_payload_regs
`default_nettype wire

// File: shared/sdi_regs_pkg.sv
// Register map constants for the EDH, format and payload register bank
`default_nettype none
package sdi_regs_pkg;
	localparam int                ADDR_W              = 8;
	localparam int                DATA_W              = 16;
	localparam int                STD_W               = 5;
	localparam int                EDH_FLAG_W          = 15;

	localparam logic [ADDR_W-1:0] OFS_EDH_FLAG_PROGRAM    = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_FORMAT_DETECT       = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RESERVED_A          = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_STANDARD_OVERRIDE   = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_EDH_VALIDITY        = 8'h07;
	localparam logic [ADDR_W-1:0] OFS_INSERT_POSITION     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RESERVED_B          = 8'h09;
	localparam logic [ADDR_W-1:0] OFS_LUMA_LOW            = 8'h0a;
	localparam logic [ADDR_W-1:0] OFS_LUMA_HIGH           = 8'h0b;
	localparam logic [ADDR_W-1:0] OFS_CHROMA_LOW          = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CHROMA_HIGH         = 8'h0d;

	// Flag register: bit 14 read-only, bit 15 reserved
	localparam int                EDH_ANC_UNKNOWN_BIT     = 14;
	localparam int                EDH_ANC_LSB             = 10;
	localparam int                EDH_FF_LSB              = 5;
	localparam int                EDH_AP_LSB              = 0;
	localparam logic [DATA_W-1:0] EDH_FLAG_WMASK          = 16'h3fff;
	localparam logic [DATA_W-1:0] EDH_FLAG_RST            = 16'h0000;

	// Format status fields
	localparam int                FMT_HLOCK_BIT           = 0;
	localparam int                FMT_VLOCK_BIT           = 1;
	localparam int                FMT_STDLOCK_BIT         = 2;
	localparam int                FMT_INTERLACE_BIT       = 4;
	localparam int                FMT_STD_LSB             = 5;

	// Standard override fields
	localparam int                OVR_CODE_LSB            = 0;
	localparam int                OVR_ENABLE_BIT          = 5;
	localparam logic [DATA_W-1:0] OVR_WMASK               = 16'h003f;
	localparam logic [DATA_W-1:0] OVR_RST                 = 16'h0000;

	// Validity status fields
	localparam int                VAL_AP_BIT              = 0;
	localparam int                VAL_FF_BIT              = 1;

	// Insertion position
	localparam int                POS_EARLIEST_BIT        = 0;
	localparam logic [DATA_W-1:0] POS_WMASK               = 16'h0001;
	localparam logic [DATA_W-1:0] POS_RST                 = 16'h0001;

	// Payload byte words
	localparam logic [DATA_W-1:0] PAYLOAD_WMASK           = 16'hffff;
	localparam logic [DATA_W-1:0] PAYLOAD_RST             = 16'h0000;
	localparam int                PAYLOAD_WORDS           = 4;
endpackage : sdi_regs_pkg
`default_nettype wire
